// >>> shared/tma_pkg.sv
// Purpose: constants, register map and carrier types for one channel
//          of the five-channel 16-bit timer group (timer and event modes)
// Assumes: 40 MHz clk_in, plain register port with 4-bit address
// Notes:   one-shot, pwm and two-phase counting are not built here
//
// Function
// - timer mode counts one of five selectable internal prescaled sources
// - timer mode decrements per source pulse; underflow reloads, requests irq
// - timer mode divides source by setting plus one, any 16-bit value
// - run bit set starts counting, run bit cleared stops counting
// - while stopped or before first pulse, count write hits reload and counter
// - once counting, count write hits reload latch only, used at next reload
// - reading the count register returns the live count in either mode
// - gate function lets the input pin start and stop timer counting
// - pulse output toggles on underflow, and on overflow in event mode
// - pulse output is driven low whenever the run bit is cleared
// - event mode counts input pin edges, active edge chosen by software
// - event source may be group timer, previous or next channel, wrapping
// - event mode counts up or down, direction from pin or software
// - event reload type reloads and continues on overflow or underflow
// - event free-run type wraps without reloading
// - event division is all-ones minus setting plus one up, setting plus one down
// - event mode requests an interrupt on every overflow or underflow
// - event mode output pin is port, pulse output or direction input
// - only channels 2, 3 and 4 may count two-phase signals
// - two-bit mode field selects operation; binary 01 is event mode
// - polarity bit zero counts falling edges, one counts rising edges
// - direction-source bit zero uses direction register, one uses output pin
// - count-type bit zero selects reload, one selects free-run
// ============================================================
// tma_pkg
package tma_pkg;

  // ============================================================
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFF_START = 4'h0; // shared_start_register
  localparam logic [3:0] OFF_MODE = 4'h1; // channel_mode_register
  localparam logic [3:0] OFF_COUNT = 4'h2; // count_reload_register
  localparam logic [3:0] OFF_DIR = 4'h3; // direction_register
  localparam logic [3:0] OFF_EVSEL = 4'h4; // event source select
  localparam logic [3:0] OFF_STATUS = 4'h5; // channel status

  // ============================================================
  // channel facts
  localparam int NUM_CHANNELS = 5;
  localparam int TWO_PHASE_FIRST = 2; // lowest channel with two-phase
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ============================================================
  // prescaler taps
  localparam int PRE_W = 5;
  localparam logic [4:0] PRE_DIV2_MASK = 5'h01;
  localparam logic [4:0] PRE_DIV8_MASK = 5'h07;
  localparam logic [4:0] PRE_DIV32_MASK = 5'h1f;

  // ============================================================
  // enumerations
  typedef enum logic [1:0] {
    TMA_OP_TIMER = 2'b00,
    TMA_OP_EVENT = 2'b01,
    TMA_OP_ONESHOT = 2'b10,
    TMA_OP_PWM = 2'b11
  } tma_op_t;

  typedef enum logic [2:0] {
    TMA_CLK_DIV1 = 3'b000,
    TMA_CLK_DIV2 = 3'b001,
    TMA_CLK_DIV8 = 3'b010,
    TMA_CLK_DIV32 = 3'b011,
    TMA_CLK_SLOW32 = 3'b100
  } tma_clk_sel_t;

  typedef enum logic [1:0] {
    TMA_EV_PIN = 2'b00,
    TMA_EV_GROUP = 2'b01,
    TMA_EV_PREV = 2'b10,
    TMA_EV_NEXT = 2'b11
  } tma_ev_sel_t;

  typedef enum logic [1:0] {
    TMA_ST_STOPPED = 2'b00,
    TMA_ST_ARMED = 2'b01,
    TMA_ST_COUNTING = 2'b10
  } tma_state_t;

  // ============================================================
  // carriers
  typedef struct packed {
    logic [2:0] clk_sel;
    logic count_type; // 0 reload, 1 free-run
    logic gate_en;
    logic direction_source_bit;
    logic edge_polarity_bit; // also gate level in timer mode
    logic pulse_en;
    logic [1:0] op_select; // op_select_high, op_select_low
  } tma_mode_t;

  localparam int MODE_W = $bits(tma_mode_t);
  localparam tma_mode_t MODE_RESET = '0;

  typedef struct packed {
    logic two_phase_cap;
    logic out_level;
    logic started;
    logic running;
  } tma_status_t;

  localparam int STATUS_W = $bits(tma_status_t);

  typedef struct packed {
    logic slow32;
    logic div32;
    logic div8;
    logic div2;
    logic div1;
  } tma_taps_t;

endpackage : tma_pkg

// >>> design/tma_prescaler.sv
// Purpose: internal prescaler, one-cycle ticks at divide 1, 2, 8, 32
// Assumes: slow_clock_div32 tick arrives already synchronous
// Notes:   taps are registered so every tick is a clean single cycle
`timescale 1ns/1ps
module tma_prescaler (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic slow_tick_in,
  output tma_pkg::tma_taps_t taps_out
);

  // ============================================================
  // divider
  logic [tma_pkg::PRE_W-1:0] div_q;
  tma_pkg::tma_taps_t taps_d;

  // divide taps fire when the low bits of the divider are all ones; slow32 passes the input tick
  assign taps_d.div1 = 1'b1;
  assign taps_d.div2 =
    (div_q & tma_pkg::PRE_DIV2_MASK) == tma_pkg::PRE_DIV2_MASK;
  assign taps_d.div8 =
    (div_q & tma_pkg::PRE_DIV8_MASK) == tma_pkg::PRE_DIV8_MASK;
  assign taps_d.div32 =
    (div_q & tma_pkg::PRE_DIV32_MASK) == tma_pkg::PRE_DIV32_MASK;
  assign taps_d.slow32 = slow_tick_in;

  // free-running divider and tap register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= '0;
      taps_out <= '0;
    end else begin
      div_q <= div_q + 1'b1;
      taps_out <= taps_d;
    end
  end

endmodule : tma_prescaler

// >>> design/tma_edge.sv
// Purpose: selectable edge detector for the channel input pin
// Assumes: pin is synchronous to clk_in
// Notes:   pulse is combinational from the held previous level
`timescale 1ns/1ps
module tma_edge (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  input wire logic rising_in,
  output logic edge_out
);

  // ============================================================
  // previous level
  logic prev_q;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
    end
  end

  // polarity one picks rising edges, zero picks falling edges
  assign edge_out = rising_in ? (pin_in & ~prev_q) : (~pin_in & prev_q);

endmodule : tma_edge

// >>> design/tma_channel.sv
// Purpose: one 16-bit channel of the timer group, timer and event modes
// Assumes: 40 MHz clk_in; all pins synchronous; register port never waits
// Notes:   modes 10 and 11 are accepted in the mode field but hold the
//          counter; two-phase counting is only reported as a capability
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tma_channel #(
  parameter int CHANNEL_INDEX = 0,
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [tma_pkg::ADDR_W-1:0] addr_in,
  input wire logic [tma_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [tma_pkg::DATA_W-1:0] rdata_out,
  input wire logic slow_tick_in,
  input wire logic input_pin_in,
  input wire logic output_pin_in,
  input wire logic group_event_in,
  input wire logic prev_event_in,
  input wire logic next_event_in,
  output logic output_pin_out,
  output logic output_pin_oe_out,
  output logic irq_out,
  output logic event_out
);

  // ============================================================
  // registers
  logic run_q;
  logic dir_q;
  tma_pkg::tma_mode_t mode_q;
  tma_pkg::tma_ev_sel_t evsel_q;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] reload_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  tma_pkg::tma_state_t state_q;
  tma_pkg::tma_state_t state_d;
  logic out_q;
  logic out_d;
  logic oe_q;
  logic irq_q;
  logic event_q;
  logic [tma_pkg::DATA_W-1:0] rdata_q;

  // ============================================================
  // address decode
  function automatic logic hit(
    input logic [tma_pkg::ADDR_W-1:0] a,
    input logic [tma_pkg::ADDR_W-1:0] off
  );
    hit = (a == off);
  endfunction : hit

  wire wr_start = wr_in & hit(addr_in, tma_pkg::OFF_START);
  wire wr_mode = wr_in & hit(addr_in, tma_pkg::OFF_MODE);
  wire wr_count = wr_in & hit(addr_in, tma_pkg::OFF_COUNT);
  wire wr_dir = wr_in & hit(addr_in, tma_pkg::OFF_DIR);
  wire wr_evsel = wr_in & hit(addr_in, tma_pkg::OFF_EVSEL);

  // ============================================================
  // count sources
  tma_pkg::tma_taps_t taps;
  logic pin_edge;

  tma_prescaler u_prescaler (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .slow_tick_in(slow_tick_in),
    .taps_out(taps)
  );

  tma_edge u_edge (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(input_pin_in),
    .rising_in(mode_q.edge_polarity_bit),
    .edge_out(pin_edge)
  );

  // mode decode
  wire is_timer = (mode_q.op_select == tma_pkg::TMA_OP_TIMER);
  wire is_event = (mode_q.op_select == tma_pkg::TMA_OP_EVENT);

  // internal tap select, one of five prescaled sources
  logic tap_tick;
  always_comb begin
    unique case (tma_pkg::tma_clk_sel_t'(mode_q.clk_sel))
      tma_pkg::TMA_CLK_DIV1: tap_tick = taps.div1;
      tma_pkg::TMA_CLK_DIV2: tap_tick = taps.div2;
      tma_pkg::TMA_CLK_DIV8: tap_tick = taps.div8;
      tma_pkg::TMA_CLK_DIV32: tap_tick = taps.div32;
      tma_pkg::TMA_CLK_SLOW32: tap_tick = taps.slow32;
      default: tap_tick = 1'b0; // unused codes never count
    endcase
  end

  // gate: polarity one counts while the pin is high, zero while low
  wire gate_open = ~mode_q.gate_en |
    (input_pin_in == mode_q.edge_polarity_bit);

  // event source; neighbour numbering wraps in the group wiring
  logic ev_tick;
  always_comb begin
    unique case (evsel_q)
      tma_pkg::TMA_EV_PIN: ev_tick = pin_edge;
      tma_pkg::TMA_EV_GROUP: ev_tick = group_event_in;
      tma_pkg::TMA_EV_PREV: ev_tick = prev_event_in;
      tma_pkg::TMA_EV_NEXT: ev_tick = next_event_in;
    endcase
  end

  // count pulse, only while the run bit is set
  wire src_tick = is_timer ? (tap_tick & gate_open) :
    (is_event & ev_tick);
  wire running = (state_q != tma_pkg::TMA_ST_STOPPED);
  // the run bit gates too, so no pulse slips in while the state catches up
  wire tick = running & run_q & src_tick;

  // ============================================================
  // direction
  // timer mode always counts down; event mode picks register or pin
  wire dir_up = is_event &
    (mode_q.direction_source_bit ? output_pin_in : dir_q);

  // ============================================================
  // wrap detection
  wire at_top = (count_q == {CNT_W{1'b1}});
  wire at_bottom = (count_q == '0);
  wire overflow = tick & dir_up & at_top;
  wire underflow = tick & ~dir_up & at_bottom;
  wire wrap = overflow | underflow;
  // timer mode always reloads; event mode reloads unless free-run
  wire reload_on_wrap = is_timer | ~mode_q.count_type;

  // ============================================================
  // state machine: stopped, armed until first pulse, counting
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tma_pkg::TMA_ST_STOPPED: begin
        if (run_q) begin
          state_d = tma_pkg::TMA_ST_ARMED;
        end
      end
      tma_pkg::TMA_ST_ARMED: begin
        if (!run_q) begin
          state_d = tma_pkg::TMA_ST_STOPPED;
        end else if (src_tick) begin
          state_d = tma_pkg::TMA_ST_COUNTING;
        end
      end
      tma_pkg::TMA_ST_COUNTING: begin
        if (!run_q) begin
          state_d = tma_pkg::TMA_ST_STOPPED;
        end
      end
      default: state_d = tma_pkg::TMA_ST_STOPPED;
    endcase
  end

  // writes before the first pulse reach the counter directly
  wire write_both = wr_count &
    (state_q != tma_pkg::TMA_ST_COUNTING);

  // ============================================================
  // reload latch and counter next values
  assign reload_d = wr_count ? wdata_in[CNT_W-1:0] : reload_q;

  // a write that lands on a wrap once counting leaves the old reload in the counter
  always_comb begin
    count_d = count_q;
    if (write_both) begin
      count_d = wdata_in[CNT_W-1:0];
    end else if (wrap && reload_on_wrap) begin
      count_d = reload_q;
    end else if (tick && dir_up) begin
      count_d = count_q + 1'b1;
    end else if (tick) begin
      count_d = count_q - 1'b1;
    end
  end

  // ============================================================
  // pulse output: toggle on each wrap, forced low when stopped
  always_comb begin
    out_d = out_q;
    if (!run_q) begin
      out_d = 1'b0;
    end else if (mode_q.pulse_en && wrap) begin
      out_d = ~out_q;
    end
  end

  // ============================================================
  // read mux; status shows the channel's own state
  tma_pkg::tma_status_t status;
  assign status.two_phase_cap =
    (CHANNEL_INDEX >= tma_pkg::TWO_PHASE_FIRST);
  assign status.out_level = out_q;
  assign status.started = (state_q == tma_pkg::TMA_ST_COUNTING);
  assign status.running = running;

  logic [tma_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (addr_in)
      tma_pkg::OFF_START: rd_mux[CHANNEL_INDEX] = run_q;
      tma_pkg::OFF_MODE: rd_mux[tma_pkg::MODE_W-1:0] = mode_q;
      tma_pkg::OFF_COUNT: rd_mux[CNT_W-1:0] = count_q;
      tma_pkg::OFF_DIR: rd_mux[CHANNEL_INDEX] = dir_q;
      tma_pkg::OFF_EVSEL: rd_mux[1:0] = evsel_q;
      tma_pkg::OFF_STATUS: rd_mux[tma_pkg::STATUS_W-1:0] = status;
      default: rd_mux = '0; // unmapped reads as zero
    endcase
  end

  // ============================================================
  // software registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      run_q <= 1'b0;
      dir_q <= 1'b0;
      mode_q <= tma_pkg::MODE_RESET;
      evsel_q <= tma_pkg::TMA_EV_PIN;
    end else begin
      if (wr_start) begin
        run_q <= wdata_in[CHANNEL_INDEX];
      end
      if (wr_dir) begin
        dir_q <= wdata_in[CHANNEL_INDEX];
      end
      if (wr_mode) begin
        mode_q <= tma_pkg::tma_mode_t'(wdata_in[tma_pkg::MODE_W-1:0]);
      end
      if (wr_evsel) begin
        evsel_q <= tma_pkg::tma_ev_sel_t'(wdata_in[1:0]);
      end
    end
  end

  // counter, reload latch and state
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= tma_pkg::TMA_ST_STOPPED;
      reload_q <= tma_pkg::COUNT_RESET[CNT_W-1:0];
      count_q <= tma_pkg::COUNT_RESET[CNT_W-1:0];
    end else begin
      state_q <= state_d;
      reload_q <= reload_d;
      count_q <= count_d;
    end
  end

  // registered outputs; irq and neighbour event are one-cycle pulses
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
      irq_q <= 1'b0;
      event_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= mode_q.pulse_en;
      irq_q <= wrap;
      event_q <= wrap;
      rdata_q <= rd_in ? rd_mux : '0;
    end
  end

  assign output_pin_out = out_q;
  assign output_pin_oe_out = oe_q;
  assign irq_out = irq_q;
  assign event_out = event_q;
  assign rdata_out = rdata_q;

endmodule : tma_channel

// >>> verification/tma_src_model.sv
// Purpose: far side of one timer channel: input pin, neighbour pulses
// Assumes: requests arrive one cycle early from the bench
// Notes:   the shared output pin resolves to the channel while it drives
`timescale 1ns/1ps
module tma_src_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] sel_in,
  input wire logic fire_in,
  input wire logic dir_in,
  input wire logic oe_in,
  input wire logic out_in,
  output logic pin_out,
  output logic group_out,
  output logic prev_out,
  output logic next_out,
  output logic dpin_out
);
  // ==========================================================
  // sources
  // pulses last one cycle, as a neighbour timer's wrap would
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_out <= 1'b0;
      group_out <= 1'b0;
      prev_out <= 1'b0;
      next_out <= 1'b0;
    end else begin
      pin_out <= pin_out ^ (fire_in && sel_in == 2'h0);
      group_out <= fire_in && sel_in == 2'h1;
      prev_out <= fire_in && sel_in == 2'h2;
      next_out <= fire_in && sel_in == 2'h3;
    end
  end
  // pin level: channel wins while it drives, else our direction level
  assign dpin_out = oe_in ? out_in : dir_in;
endmodule : tma_src_model

// >>> verification/tma_channel_asserts.sv
// Purpose: port checks for one timer channel
// Assumes: one clock domain; shadows mirror software writes
// Notes:   shadows see the register port only, not the counter
`timescale 1ns/1ps
module tma_channel_chk #(
  parameter int CHANNEL_INDEX = 0,
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [tma_pkg::ADDR_W-1:0] addr_in,
  input wire logic [tma_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [tma_pkg::DATA_W-1:0] rdata_out,
  input wire logic output_pin_out,
  input wire logic output_pin_oe_out,
  input wire logic irq_out,
  input wire logic event_out
);
  // ==========================================================
  // shadows
  logic run_q;
  logic pulse_q;
  // run bit and pulse enable as software last wrote them
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      run_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == tma_pkg::OFF_START) begin
        run_q <= wdata_in[CHANNEL_INDEX];
      end
      if (wr_in && addr_in == tma_pkg::OFF_MODE) begin
        pulse_q <= wdata_in[2];
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================================
  // properties
  property p_pair;
    irq_out == event_out;
  endproperty
  a_pair: assert property (p_pair)
    else $error("irq and event pulses differ");
  property p_rise;
    $rose(output_pin_out) |-> irq_out;
  endproperty
  a_rise: assert property (p_rise)
    else $error("pulse pin rose without a wrap");
  property p_fall;
    $fell(output_pin_out) |-> irq_out || $past(wr_in) || $past(wr_in, 2);
  endproperty
  a_fall: assert property (p_fall)
    else $error("pulse pin fell without wrap or stop");
  // a stop takes one cycle to land, so only a settled stop is quiet
  property p_stop;
    !run_q && !$past(run_q) |-> !irq_out;
  endproperty
  a_stop: assert property (p_stop)
    else $error("irq while stopped");
  property p_idle;
    !$past(rd_in) |-> rdata_out == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read slot");
  property p_unmap;
    $past(rd_in && addr_in > tma_pkg::OFF_STATUS) |-> rdata_out == '0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_cap;
    $past(rd_in && addr_in == tma_pkg::OFF_STATUS) |->
      rdata_out[3] == (CHANNEL_INDEX >= tma_pkg::TWO_PHASE_FIRST);
  endproperty
  a_cap: assert property (p_cap)
    else $error("two-phase capability bit wrong");
  property p_oe;
    output_pin_oe_out == $past(pulse_q);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable does not follow pulse enable");
  c_irq: cover property (irq_out && run_q);
  c_rise: cover property ($rose(output_pin_out));
  c_cap: cover property ($past(rd_in && addr_in == tma_pkg::OFF_STATUS));
endmodule : tma_channel_chk

bind tma_channel tma_channel_chk #(.CHANNEL_INDEX(CHANNEL_INDEX),
  .CNT_W(CNT_W)) u_chk (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .output_pin_out, .output_pin_oe_out, .irq_out,
  .event_out);

// >>> verification/tma_channel_tb.sv
// Purpose: self-checking bench for one timer channel
// Assumes: channel index 2, slow tick every third cycle
// Notes:   irq pulses are tallied by a monitor, periods by waits
`timescale 1ns/1ps
module tma_channel_tb;
  localparam int CI = 2;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow_tick = 1'b0;
  logic [1:0] sc = 2'h0;
  logic [1:0] sel = 2'h0;
  logic fire = 1'b0;
  logic dir = 1'b0;
  logic pin, grp, prv, nxt, dpin, out, oe, irq, ev;
  logic [15:0] rdata;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_irq = 0;
  tma_channel #(.CHANNEL_INDEX(CI)) u_dut (.clk_in(clk_in),
    .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .slow_tick_in(slow_tick),
    .input_pin_in(pin), .output_pin_in(dpin), .group_event_in(grp),
    .prev_event_in(prv), .next_event_in(nxt), .output_pin_out(out),
    .output_pin_oe_out(oe), .irq_out(irq), .event_out(ev));
  tma_src_model u_src (.clk_in(clk_in), .reset_in(reset_in), .sel_in(sel),
    .fire_in(fire), .dir_in(dir), .oe_in(oe), .out_in(out), .pin_out(pin),
    .group_out(grp), .prev_out(prv), .next_out(nxt), .dpin_out(dpin));
  // ==========================================================
  // clock, slow tick, irq tally
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    sc <= (sc == 2'h2) ? 2'h0 : sc + 2'h1;
    slow_tick <= (sc == 2'h2);
    if (irq === 1'b1) n_irq <= n_irq + 1;
  end
  // ==========================================================
  // helpers
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : idle
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic fire_src(logic [1:0] s);
    @(posedge clk_in);
    sel <= s;
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    idle(3);
  endtask : fire_src
  // the edge count between two wraps is the period
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      idle(1);
      n++;
    end while (irq !== 1'b1 && n < 2000);
    if (irq !== 1'b1) begin
      n_mismatch++;
      $display("FAIL irq expected 1 seen %b", irq);
      give_verdict();
    end
  endtask : wait_irq
  task automatic start(logic on);
    wr_reg(tma_pkg::OFF_START, on ? 16'(1 << CI) : 16'h0000);
  endtask : start
  // ==========================================================
  // scenarios
  task automatic t_reset_map();
    logic [15:0] d;
    rd_reg(tma_pkg::OFF_MODE, d);
    chk("mode reset", 16'h0000, d);
    rd_reg(tma_pkg::OFF_STATUS, d);
    chk("status", 16'h0008, d);
    wr_reg(4'h9, 16'hffff);
    rd_reg(4'h9, d);
    chk("unmapped", 16'h0000, d);
  endtask : t_reset_map
  task automatic t_timer_taps();
    int f [5] = '{1, 2, 8, 32, 3};
    int n;
    logic lvl;
    logic [15:0] d;
    for (int i = 0; i < 5; i++) begin
      wr_reg(tma_pkg::OFF_MODE, 16'((i << 7) | 4));
      wr_reg(tma_pkg::OFF_COUNT, 16'h0002);
      rd_reg(tma_pkg::OFF_COUNT, d);
      chk("stopped write", 16'h0002, d);
      start(1'b1);
      wait_irq(n);
      lvl = out;
      wait_irq(n);
      chk("period", 16'(3 * f[i]), 16'(n));
      chk("toggle", {15'h0, ~lvl}, {15'h0, out});
      start(1'b0);
      idle(1);
      chk("low stopped", 16'h0000, {15'h0, out});
    end
  endtask : t_timer_taps
  task automatic t_reload_write();
    int n;
    logic [15:0] d;
    wr_reg(tma_pkg::OFF_MODE, 16'h0104);
    wr_reg(tma_pkg::OFF_COUNT, 16'h0064);
    start(1'b1);
    wait_irq(n);
    wr_reg(tma_pkg::OFF_COUNT, 16'h0005);
    rd_reg(tma_pkg::OFF_COUNT, d);
    chk("live count", 16'h0001, 16'(d >= 16'h0062 && d <= 16'h0064));
    wait_irq(n);
    wait_irq(n);
    chk("new period", 16'h0030, 16'(n));
    start(1'b0);
  endtask : t_reload_write
  // rising edges, up by register, free-run; then down by pin, reload
  task automatic t_event_pin();
    int k0;
    logic [15:0] d;
    wr_reg(tma_pkg::OFF_MODE, 16'h004d);
    wr_reg(tma_pkg::OFF_DIR, 16'(1 << CI));
    wr_reg(tma_pkg::OFF_COUNT, 16'hfffd);
    start(1'b1);
    repeat (4) fire_src(2'h0);
    rd_reg(tma_pkg::OFF_COUNT, d);
    chk("up count", 16'hffff, d);
    k0 = n_irq;
    repeat (2) fire_src(2'h0);
    rd_reg(tma_pkg::OFF_COUNT, d);
    chk("free wrap", 16'h0000, d);
    chk("overflow irq", 16'h0001, 16'(n_irq - k0));
    start(1'b0);
    wr_reg(tma_pkg::OFF_MODE, 16'h0019);
    wr_reg(tma_pkg::OFF_COUNT, 16'h0001);
    start(1'b1);
    k0 = n_irq;
    repeat (4) fire_src(2'h0);
    rd_reg(tma_pkg::OFF_COUNT, d);
    chk("pin down reload", 16'h0001, d);
    chk("underflow irq", 16'h0001, 16'(n_irq - k0));
    start(1'b0);
  endtask : t_event_pin
  task automatic t_event_src();
    logic [1:0] s [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    int k0;
    wr_reg(tma_pkg::OFF_MODE, 16'h0001);
    // count down from zero so every event underflows
    wr_reg(tma_pkg::OFF_DIR, 16'h0000);
    wr_reg(tma_pkg::OFF_COUNT, 16'h0000);
    start(1'b1);
    for (int i = 0; i < 5; i++) begin
      wr_reg(tma_pkg::OFF_EVSEL, {14'h0, s[i]});
      k0 = n_irq;
      fire_src(s[i]);
      chk("source", 16'(i > 0), 16'(n_irq - k0));
    end
    start(1'b0);
  endtask : t_event_src
  task automatic t_gate();
    int k0;
    logic [15:0] d;
    wr_reg(tma_pkg::OFF_MODE, 16'h0028);
    wr_reg(tma_pkg::OFF_COUNT, 16'h0003);
    start(1'b1);
    k0 = n_irq;
    idle(20);
    chk("gate shut", 16'h0000, 16'(n_irq - k0));
    fire_src(2'h0);
    k0 = n_irq;
    idle(20);
    chk("gate open", 16'h0001, 16'((n_irq - k0) inside {[4:5]}));
    start(1'b0);
    // mode code 10 is outside timer and event, so the counter must hold
    wr_reg(tma_pkg::OFF_MODE, 16'h0002);
    wr_reg(tma_pkg::OFF_COUNT, 16'h0003);
    start(1'b1);
    idle(10);
    rd_reg(tma_pkg::OFF_COUNT, d);
    chk("mode held", 16'h0003, d);
    start(1'b0);
  endtask : t_gate
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset_map();
    t_timer_taps();
    t_reload_write();
    t_event_pin();
    t_event_src();
    t_gate();
    give_verdict();
  end
endmodule : tma_channel_tb
